// ===== hw/smr_defs.vh
`ifndef SMR_DEFS_VH
`define SMR_DEFS_VH
// Clock rate and sequence tag timing.
`define SMR_CLK_KHZ 200000
`define SMR_TAG_MS 50
`define SMR_TICK_CYCLES (`SMR_TAG_MS * `SMR_CLK_KHZ)
`define SMR_TAG_WRAP 16'h8CA0
// Register byte offsets.
`define SMR_OFF_CTRL 12'h000
`define SMR_OFF_INTERVAL 12'h004
`define SMR_OFF_ELEV_MASK 12'h008
`define SMR_OFF_MIN_SV 12'h00C
`define SMR_OFF_STATUS 12'h010
// Control register fields.
`define SMR_CTRL_ENABLE 0
`define SMR_CTRL_PHASE_OPT 1
`define SMR_CTRL_TSCALE 2
// Reset values.
`define SMR_RST_CTRL 32'h0000_0001
`define SMR_RST_INTERVAL 32'h0000_0014
`define SMR_RST_ELEV_MASK 32'h0000_0005
`define SMR_RST_MIN_SV 32'h0000_0001
// Record layout.
`define SMR_BODY_BYTES 8'h24
`define SMR_REC_BITS 288
`define SMR_PHASE_QUALITY 8'h00
// Warning byte bit positions.
`define SMR_WARN_NAV_LO 0
`define SMR_WARN_NAV_HI 1
`define SMR_WARN_NOSYNC 2
`define SMR_WARN_UNSMOOTH 3
`define SMR_WARN_RSVD5 4
`define SMR_WARN_LOCKLOST 5
`define SMR_WARN_RSVD7 6
`define SMR_WARN_CONTIN 7
// AXI responses.
`define SMR_RESP_OKAY 2'b00
`define SMR_RESP_SLVERR 2'b10
`endif

// ===== hw/smr_framer.v
`include "smr_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module smr_framer #(
    parameter NCH = 12,
    parameter TICK_CYCLES = `SMR_TICK_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [7:0] sat_sel,
    input wire meas_locked,
    input wire [7:0] meas_elev,
    input wire [7:0] meas_prn,
    input wire [7:0] meas_azim,
    input wire [7:0] meas_chan,
    input wire [7:0] meas_goodbad,
    input wire [7:0] meas_polarity,
    input wire [7:0] meas_snr,
    input wire [63:0] meas_phase,
    input wire [63:0] meas_range,
    input wire [63:0] meas_range_adj,
    input wire meas_sys,
    input wire [31:0] meas_doppler,
    input wire [7:0] meas_smooth_count,
    input wire meas_corr_sign,
    input wire [22:0] meas_corr_mag,
    input wire meas_nav_obtained,
    input wire meas_nav_used,
    input wire meas_sym_sync,
    input wire meas_lock_lost,
    input wire meas_reacquired,
    input wire meas_polarity_found,
    input wire fatal_fail,
    output reg [7:0] rec_data,
    output reg rec_valid,
    output reg rec_last,
    input wire rec_ready
);
    localparam ST_IDLE = 6'b000001;
    localparam ST_COUNT = 6'b000010;
    localparam ST_CHECK = 6'b000100;
    localparam ST_SCAN = 6'b001000;
    localparam ST_SEND = 6'b010000;
    localparam ST_CSUM = 6'b100000;

    reg [31:0] ctrl_reg;
    reg [31:0] interval_reg;
    reg [31:0] elev_mask_reg;
    reg [31:0] min_sv_reg;
    reg [11:0] aw_addr_reg;
    reg aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_held_reg;
    reg [31:0] tick_cnt_reg;
    reg [15:0] seq_tag_reg;
    reg [15:0] epoch_tag_reg;
    reg [15:0] ival_cnt_reg;
    reg epoch_pend_reg;
    reg fatal_reg;
    reg [5:0] state_reg;
    reg [7:0] locked_cnt_reg;
    reg [7:0] elig_cnt_reg;
    reg [7:0] left_reg;
    reg [7:0] byte_idx_reg;
    reg [7:0] csum_reg;
    reg [7:0] last_locked_reg;
    reg [`SMR_REC_BITS-1:0] rec_reg;

    wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
    wire eligible = meas_locked && (meas_elev >= elev_mask_reg[7:0]);
    wire last_sat = (sat_sel == NCH - 1);
    wire [7:0] csum_next = csum_reg ^ rec_data;
    reg [7:0] warn;
    reg [31:0] smooth_word;
    reg [63:0] phase_field;
    reg [63:0] range_field;
    reg [31:0] status_word;
    reg [31:0] rd_word;
    reg rd_hit;

    function [31:0] apply_strb;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            apply_strb = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    apply_strb[i*8 +: 8] = data[i*8 +: 8];
        end
    endfunction

    always @*
    begin
        warn = 8'h00;
        warn[`SMR_WARN_NAV_LO] = meas_nav_obtained && !meas_nav_used;
        warn[`SMR_WARN_NAV_HI] = meas_nav_obtained && meas_nav_used;
        warn[`SMR_WARN_NOSYNC] = !meas_sym_sync;
        warn[`SMR_WARN_UNSMOOTH] = (meas_smooth_count == 8'h00);
        warn[`SMR_WARN_RSVD5] = 1'b0;
        warn[`SMR_WARN_LOCKLOST] = meas_lock_lost;
        warn[`SMR_WARN_RSVD7] = 1'b0;
        warn[`SMR_WARN_CONTIN] = meas_reacquired || meas_polarity_found;
        smooth_word = {meas_smooth_count, meas_corr_sign, meas_corr_mag};
        phase_field = ctrl_reg[`SMR_CTRL_PHASE_OPT] ? meas_phase : 64'h0000_0000_0000_0000;
        // Tracking supplies both range forms; the adjusted one is used when meas_sys differs from the time scale bit.
        range_field = (meas_sys != ctrl_reg[`SMR_CTRL_TSCALE]) ? meas_range_adj : meas_range;
        status_word = {seq_tag_reg, last_locked_reg, 6'b00_0000, !state_reg[0], fatal_reg};
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `SMR_OFF_CTRL: rd_word = ctrl_reg;
            `SMR_OFF_INTERVAL: rd_word = interval_reg;
            `SMR_OFF_ELEV_MASK: rd_word = elev_mask_reg;
            `SMR_OFF_MIN_SV: rd_word = min_sv_reg;
            `SMR_OFF_STATUS: rd_word = status_word;
            default:
            begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= `SMR_RST_CTRL;
            interval_reg <= `SMR_RST_INTERVAL;
            elev_mask_reg <= `SMR_RST_ELEV_MASK;
            min_sv_reg <= `SMR_RST_MIN_SV;
            aw_addr_reg <= 12'h000;
            aw_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            w_held_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SMR_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SMR_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_reg && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_reg && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
            end
            if (aw_held_reg && w_held_reg && !s_axi_bvalid)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SMR_RESP_OKAY;
                case (aw_addr_reg)
                    `SMR_OFF_CTRL: ctrl_reg <= apply_strb(ctrl_reg, w_data_reg, w_strb_reg);
                    `SMR_OFF_INTERVAL:
                        interval_reg <= apply_strb(interval_reg, w_data_reg, w_strb_reg);
                    `SMR_OFF_ELEV_MASK:
                        elev_mask_reg <= apply_strb(elev_mask_reg, w_data_reg, w_strb_reg);
                    `SMR_OFF_MIN_SV: min_sv_reg <= apply_strb(min_sv_reg, w_data_reg, w_strb_reg);
                    `SMR_OFF_STATUS: s_axi_bresp <= `SMR_RESP_OKAY;
                    default: s_axi_bresp <= `SMR_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `SMR_RESP_OKAY : `SMR_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Sequence tag and recording interval timing.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_cnt_reg <= 32'h0000_0000;
            seq_tag_reg <= 16'h0000;
            ival_cnt_reg <= 16'h0000;
            epoch_pend_reg <= 1'b0;
            fatal_reg <= 1'b0;
        end
        else
        begin
            if (fatal_fail)
                fatal_reg <= 1'b1;
            // The clear comes first so that a new epoch flag set by this tick wins.
            if (state_reg == ST_IDLE && epoch_pend_reg)
                epoch_pend_reg <= 1'b0;
            tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
            if (tick)
                seq_tag_reg <= (seq_tag_reg == `SMR_TAG_WRAP - 16'h0001) ?
                    16'h0000 : seq_tag_reg + 16'h0001;
            if (tick && interval_reg[15:0] != 16'h0000)
            begin
                if (ival_cnt_reg >= interval_reg[15:0] - 16'h0001)
                begin
                    ival_cnt_reg <= 16'h0000;
                    epoch_pend_reg <= ctrl_reg[`SMR_CTRL_ENABLE];
                end
                else
                    ival_cnt_reg <= ival_cnt_reg + 16'h0001;
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            sat_sel <= 8'h00;
            locked_cnt_reg <= 8'h00;
            elig_cnt_reg <= 8'h00;
            left_reg <= 8'h00;
            byte_idx_reg <= 8'h00;
            csum_reg <= 8'h00;
            last_locked_reg <= 8'h00;
            epoch_tag_reg <= 16'h0000;
            rec_reg <= {`SMR_REC_BITS{1'b0}};
            rec_data <= 8'h00;
            rec_valid <= 1'b0;
            rec_last <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (epoch_pend_reg && !fatal_reg)
                    begin
                        sat_sel <= 8'h00;
                        locked_cnt_reg <= 8'h00;
                        elig_cnt_reg <= 8'h00;
                        // All records of one epoch carry the same measurement time.
                        epoch_tag_reg <= seq_tag_reg;
                        state_reg <= ST_COUNT;
                    end
                ST_COUNT:
                begin
                    locked_cnt_reg <= locked_cnt_reg + {7'h00, meas_locked};
                    elig_cnt_reg <= elig_cnt_reg + {7'h00, eligible};
                    sat_sel <= last_sat ? 8'h00 : sat_sel + 8'h01;
                    if (last_sat)
                        state_reg <= ST_CHECK;
                end
                ST_CHECK:
                begin
                    last_locked_reg <= locked_cnt_reg;
                    left_reg <= elig_cnt_reg;
                    if (fatal_reg || locked_cnt_reg < min_sv_reg[7:0] || elig_cnt_reg == 8'h00)
                        state_reg <= ST_IDLE;
                    else
                        state_reg <= ST_SCAN;
                end
                ST_SCAN:
                    if (fatal_reg)
                        state_reg <= ST_IDLE;
                    else if (eligible && left_reg != 8'h00)
                    begin
                        rec_reg <= {epoch_tag_reg, left_reg - 8'h01, meas_prn, meas_elev, meas_azim,
                            meas_chan, warn, meas_goodbad, meas_polarity, meas_snr,
                            `SMR_PHASE_QUALITY, phase_field, range_field, meas_doppler,
                            smooth_word};
                        rec_data <= epoch_tag_reg[15:8];
                        rec_valid <= 1'b1;
                        left_reg <= left_reg - 8'h01;
                        byte_idx_reg <= 8'h00;
                        csum_reg <= 8'h00;
                        state_reg <= ST_SEND;
                    end
                    else if (last_sat || left_reg == 8'h00)
                        state_reg <= ST_IDLE;
                    else
                        sat_sel <= sat_sel + 8'h01;
                ST_SEND:
                    if (rec_ready)
                    begin
                        csum_reg <= csum_next;
                        if (byte_idx_reg == `SMR_BODY_BYTES - 8'h01)
                        begin
                            rec_data <= csum_next;
                            rec_last <= 1'b1;
                            state_reg <= ST_CSUM;
                        end
                        else
                        begin
                            rec_data <= rec_reg[`SMR_REC_BITS-9 -: 8];
                            rec_reg <= {rec_reg[`SMR_REC_BITS-9:0], 8'h00};
                            byte_idx_reg <= byte_idx_reg + 8'h01;
                        end
                    end
                ST_CSUM:
                    if (rec_ready)
                    begin
                        rec_valid <= 1'b0;
                        rec_last <= 1'b0;
                        if (last_sat)
                            state_reg <= ST_IDLE;
                        else
                        begin
                            sat_sel <= sat_sel + 8'h01;
                            state_reg <= ST_SCAN;
                        end
                    end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // smr_framer
`default_nettype wire

// ===== hw/smr_framer_dummy_unused.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== tb/smr_framer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module smr_framer_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic fatal_fail,
    input wire logic [7:0] rec_data,
    input wire logic rec_valid,
    input wire logic rec_last,
    input wire logic rec_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [5:0] idx_reg;
    logic [7:0] sum_reg;
    logic [2:0] fatal_reg;
    // Byte position and running XOR of the record on the wire, plus a delayed sticky fatal.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            idx_reg <= 6'h00;
            sum_reg <= 8'h00;
            fatal_reg <= 3'h0;
        end
        else
        begin
            fatal_reg <= {fatal_reg[1:0], fatal_reg[0] | fatal_fail};
            if (rec_valid && rec_ready)
            begin
                idx_reg <= rec_last ? 6'h00 : idx_reg + 6'h01;
                sum_reg <= rec_last ? 8'h00 : sum_reg ^ rec_data;
            end
        end
    end
    a_hold_byte: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
        else $error("record byte changed before acceptance");
    a_gap_after_last: assert property (rec_valid && rec_ready && rec_last |=> !rec_valid)
        else $error("no idle cycle after record end");
    a_last_at_end: assert property (rec_valid |-> rec_last == (idx_reg == 6'h24))
        else $error("last flag not on byte 36");
    a_checksum_byte: assert property (rec_valid && rec_last |-> rec_data == sum_reg)
        else $error("checksum byte wrong");
    a_phase_quality: assert property (rec_valid && idx_reg == 6'h0b |-> rec_data == 8'h00)
        else $error("phase quality byte not zero");
    a_warn_reserved: assert property (rec_valid && idx_reg == 6'h07 |-> !rec_data[4] && !rec_data[6])
        else $error("reserved warning bits set");
    a_fatal_silence: assert property (fatal_reg[2] && idx_reg == 6'h00 |-> !rec_valid)
        else $error("record started after fatal failure");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not withdrawn");
    cover property (rec_valid && rec_ready && rec_last);
    cover property (rec_valid && !rec_ready);
    cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // smr_framer_chk
bind smr_framer smr_framer_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rresp(s_axi_rresp), .fatal_fail(fatal_fail), .rec_data(rec_data),
    .rec_valid(rec_valid), .rec_last(rec_last), .rec_ready(rec_ready));
`default_nettype wire

// ===== tb/smr_host_sink.sv
`timescale 1ns/10ps
`default_nettype none
module smr_host_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] rec_data,
    input wire logic rec_valid,
    input wire logic rec_last,
    input wire logic slow,
    output logic rec_ready,
    output logic [295:0] rec_bits,
    output int n_rec
);
    initial rec_ready = 1'b0;
    // A slow host accepts on every other cycle only.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rec_ready <= 1'b0;
            n_rec <= 0;
        end
        else
        begin
            rec_ready <= slow ? ~rec_ready : 1'b1;
            if (rec_valid && rec_ready)
                rec_bits <= {rec_bits[287:0], rec_data};
            if (rec_valid && rec_ready && rec_last)
                n_rec <= n_rec + 1;
        end
    end
endmodule // smr_host_sink
`default_nettype wire

// ===== tb/smr_framer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "smr_defs.vh"
module smr_framer_tb;
    localparam int NCH = 4;
    localparam int IVL = 40;
    logic aclk = 0, aresetn = 0, fatal_fail = 0, slow = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rec_valid, rec_last, rec_ready, meas_locked, meas_sys, meas_corr_sign;
    logic meas_nav_obtained, meas_nav_used, meas_sym_sync, meas_lock_lost, meas_reacquired;
    logic meas_polarity_found;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] sat_sel, rec_data, meas_elev, meas_prn, meas_azim, meas_chan, meas_goodbad;
    logic [7:0] meas_polarity, meas_snr, meas_smooth_count;
    logic [63:0] meas_phase, meas_range, meas_range_adj;
    logic [31:0] meas_doppler;
    logic [22:0] meas_corr_mag;
    logic [55:0] id [NCH];
    logic [7:0] fl [NCH];
    logic [63:0] ph [NCH], rg [NCH], ra [NCH];
    logic [31:0] dp [NCH], sm [NCH];
    logic [295:0] rec;
    logic [15:0] ptg;
    int c, n_rec, n_errors = 0, comparisons = 0, cyc = 0;
    always #2.5 aclk = ~aclk;
    // Tracking logic answers at once for the channel that the framer selects.
    always_comb
    begin
        c = sat_sel % NCH;
        {meas_prn, meas_elev, meas_azim, meas_chan, meas_goodbad, meas_polarity, meas_snr} = id[c];
        {meas_polarity_found, meas_reacquired, meas_lock_lost, meas_sym_sync, meas_nav_used,
            meas_nav_obtained, meas_sys, meas_locked} = fl[c];
        {meas_smooth_count, meas_corr_sign, meas_corr_mag} = sm[c];
        {meas_phase, meas_range, meas_range_adj, meas_doppler} = {ph[c], rg[c], ra[c], dp[c]};
    end
    smr_framer #(.NCH(NCH), .TICK_CYCLES(20)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sat_sel,
        .meas_locked, .meas_elev, .meas_prn, .meas_azim, .meas_chan, .meas_goodbad,
        .meas_polarity, .meas_snr, .meas_phase, .meas_range, .meas_range_adj, .meas_sys,
        .meas_doppler, .meas_smooth_count, .meas_corr_sign, .meas_corr_mag, .meas_nav_obtained,
        .meas_nav_used, .meas_sym_sync, .meas_lock_lost, .meas_reacquired,
        .meas_polarity_found, .fatal_fail, .rec_data, .rec_valid, .rec_last, .rec_ready);
    smr_host_sink i_host (.aclk, .aresetn, .rec_data, .rec_valid, .rec_last, .slow, .rec_ready,
        .rec_bits(rec), .n_rec);
    task automatic summarize;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        comparisons++;
        if (got !== ex)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("write response", er, s_axi_bresp);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("read data", {er, ed}, {s_axi_rresp, s_axi_rdata});
        @(posedge aclk);
    endtask
    // New random measurements; channels 0 and 1 stay locked, or only channel 0 when too few.
    task automatic gen(input bit dead);
        logic [7:0] f;
        for (int i = 0; i < NCH; i++)
        begin
            f = 8'($urandom);
            f[3] = f[3] & f[2];
            f[0] = dead ? i == 0 : (f[0] || i < 2);
            fl[i] <= f;
            id[i] <= {8'($urandom), i == 0 ? 8'h1e : 8'($urandom % 91), 40'({$urandom, $urandom})};
            sm[i] <= {$urandom % 2 ? 8'h00 : 8'($urandom % 101), 24'($urandom)};
            dp[i] <= $urandom;
            ph[i] <= {$urandom, $urandom};
            rg[i] <= {$urandom, $urandom};
            ra[i] <= {$urandom, $urandom};
        end
    endtask
    task automatic epoch(input int ep, input logic [31:0] ctl);
        int n, k;
        bit fst;
        logic [7:0] e [37];
        logic [191:0] tl;
        n = 0;
        fst = 1;
        for (int i = 0; i < NCH; i++)
            n += (fl[i][0] && id[i][47:40] >= 8'h1e);
        for (int i = 0; i < NCH; i++)
        begin
            if (fl[i][0] && id[i][47:40] >= 8'h1e)
            begin
                k = n_rec;
                while (n_rec == k)
                    @(posedge aclk);
                n--;
                if (fst && ep == 0)
                    ptg = rec[295:280];
                else if (fst)
                    ptg = ptg + 16'(IVL);
                fst = 0;
                {e[0], e[1]} = ptg;
                e[2] = 8'(n);
                {e[3], e[4], e[5], e[6], e[8], e[9], e[10]} = id[i];
                e[7] = {fl[i][6] | fl[i][7], 1'b0, fl[i][5], 1'b0, sm[i][31:24] == 8'h00,
                    !fl[i][4], fl[i][3], fl[i][2] & !fl[i][3]};
                e[11] = 8'h00;
                tl = {ctl[1] ? ph[i] : 64'h0, fl[i][1] != ctl[2] ? ra[i] : rg[i], dp[i], sm[i]};
                e[36] = 8'h00;
                for (int j = 0; j < 36; j++)
                begin
                    if (j >= 12)
                        e[j] = tl[191 - 8 * (j - 12) -: 8];
                    e[36] ^= e[j];
                end
                for (int j = 0; j < 37; j++)
                    chk($sformatf("record byte %0d", j), e[j], rec[295 - 8 * j -: 8]);
            end
        end
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            summarize();
        end
    end
    initial
    begin
        int k;
        void'($urandom(32'h65c3f8ae));
        gen(0);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`SMR_OFF_CTRL, `SMR_RST_CTRL, `SMR_RESP_OKAY);
        rd(`SMR_OFF_INTERVAL, `SMR_RST_INTERVAL, `SMR_RESP_OKAY);
        rd(`SMR_OFF_ELEV_MASK, `SMR_RST_ELEV_MASK, `SMR_RESP_OKAY);
        rd(`SMR_OFF_MIN_SV, `SMR_RST_MIN_SV, `SMR_RESP_OKAY);
        rd(12'h020, 32'h0000_0000, `SMR_RESP_SLVERR);
        wr(12'h020, 32'h0000_0001, `SMR_RESP_SLVERR);
        wr(`SMR_OFF_STATUS, 32'h0000_0001, `SMR_RESP_OKAY);
        wr(`SMR_OFF_INTERVAL, IVL, `SMR_RESP_OKAY);
        wr(`SMR_OFF_ELEV_MASK, 32'h0000_001e, `SMR_RESP_OKAY);
        wr(`SMR_OFF_MIN_SV, 32'h0000_0002, `SMR_RESP_OKAY);
        rd(`SMR_OFF_MIN_SV, 32'h0000_0002, `SMR_RESP_OKAY);
        for (int ep = 0; ep < 4; ep++)
        begin
            slow <= ep[0];
            wr(`SMR_OFF_CTRL, 32'h0000_0001 | (ep << 1), `SMR_RESP_OKAY);
            epoch(ep, 32'h0000_0001 | (ep << 1));
            gen(ep == 3);
        end
        k = n_rec;
        repeat (2 * IVL * 20) @(posedge aclk);
        chk("records with too few locked", k, n_rec);
        fatal_fail <= 1'b1;
        @(posedge aclk);
        fatal_fail <= 1'b0;
        gen(0);
        repeat (2 * IVL * 20) @(posedge aclk);
        chk("records after fatal failure", k, n_rec);
        summarize();
    end
endmodule // smr_framer_tb
`default_nettype wire
